/* i2cpc_ctrl.sv */
/*
 * Control register and error flags of the two-wire serial port, with
 * AXI4-Lite slave, interrupt status/mask and pin handover.
 * Assumes buffer/shifter signals come from logic on clk_in; pins are async.
 */
`timescale 1ns/100ps
`default_nettype none
module i2cpc_ctrl (
    input wire logic clk_in,
    input wire logic resetn_in,
    // AXI4-Lite
    input wire logic [3:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [3:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    // Datapath side
    input wire logic buf_write_in,
    input wire logic bus_start_ok_in,
    input wire logic tx_in_progress_in,
    input wire logic rx_byte_done_in,
    input wire logic buffer_full_in,
    input wire logic port_clk_hold_in,
    // Pins
    input wire logic sda_pin_in,
    input wire logic scl_pin_in,
    output logic port_active_out,
    output logic [3:0] port_mode_select_out,
    output logic master_mode_out,
    output logic slave_mode_out,
    output logic scl_oe_n_out,
    output logic irq_out
);
    import i2cpc_pkg::*;

    logic write_collision_flag_ff, receive_overflow_flag_ff;
    logic serial_port_enable_ff, clock_release_ctl_ff;
    logic [3:0] port_mode_select_ff;
    logic [1:0] irq_status_ff, irq_mask_ff;
    logic [3:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic aw_held_ff, w_held_ff;
    logic [1:0] pins_sync;

    // Mode decode
    function automatic logic is_slave(input logic [3:0] m);
        is_slave = (m == MODE_SLV7) || (m == MODE_SLV10) ||
            (m == MODE_SLV7_SP) || (m == MODE_SLV10_SP); // RL9
    endfunction : is_slave

    function automatic logic is_master(input logic [3:0] m);
        is_master = (m == MODE_MST) || (m == MODE_FWMST); // RL9
    endfunction : is_master

    // ==========================================================
    // Pin synchroniser
    i2cpc_sync #(.WIDTH(2)) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in({sda_pin_in, scl_pin_in}),
        .sync_out(pins_sync)
    );

    // ==========================================================
    // Mode and event decode
    wire mode_slave = serial_port_enable_ff && is_slave(port_mode_select_ff);
    wire mode_master = serial_port_enable_ff &&
        is_master(port_mode_select_ff);
    wire coll_master = mode_master && buf_write_in && !bus_start_ok_in; // RL1
    wire coll_slave = mode_slave && buf_write_in && tx_in_progress_in; // RL2
    wire coll_evt = coll_master || coll_slave;
    // Overflow only when receiving in slave mode
    wire ovf_evt = mode_slave && !tx_in_progress_in && rx_byte_done_in &&
        buffer_full_in; // RL3 RL4 RL10

    // ==========================================================
    // AXI write decode
    wire aw_take = s_axi_awvalid_in && s_axi_awready_out;
    wire w_take = s_axi_wvalid_in && s_axi_wready_out;
    wire aw_have = aw_held_ff || aw_take;
    wire w_have = w_held_ff || w_take;
    wire [3:0] wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr_in;
    wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata_in;
    wire [3:0] wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb_in;
    wire wr_fire = aw_have && w_have && !s_axi_bvalid_out;
    wire wr_lane0 = wr_fire && wr_strb[0];
    wire wr_ctrl = wr_lane0 && (wr_addr == CTRL_OFFSET);
    wire wr_stat = wr_lane0 && (wr_addr == IRQ_STATUS_OFFSET);
    wire wr_mask = wr_lane0 && (wr_addr == IRQ_MASK_OFFSET);
    wire wr_ok = (wr_addr == CTRL_OFFSET) || (wr_addr == IRQ_STATUS_OFFSET) ||
        (wr_addr == IRQ_MASK_OFFSET) || (wr_addr == PIN_STATE_OFFSET);

    // Flag next values: a set beats a firmware clear
    wire nxt_write_collision_flag = coll_evt ? 1'b1 :
        (wr_ctrl ? (write_collision_flag_ff & wr_data[WRITE_COLLISION_FLAG_BIT]) :
        write_collision_flag_ff); // RL5
    wire nxt_rov = ovf_evt ? 1'b1 :
        (wr_ctrl ? (receive_overflow_flag_ff & wr_data[ROV_BIT]) :
        receive_overflow_flag_ff); // RL5
    wire [1:0] nxt_irq_status = {ovf_evt, coll_evt} |
        (irq_status_ff & ~(wr_stat ? wr_data[1:0] : 2'h0));

    // ==========================================================
    // AXI read decode
    wire rd_fire = s_axi_arvalid_in && s_axi_arready_out;
    wire [7:0] ctrl_rd = {write_collision_flag_ff, receive_overflow_flag_ff,
        serial_port_enable_ff, clock_release_ctl_ff, port_mode_select_ff};
    wire rd_ok = (s_axi_araddr_in == CTRL_OFFSET) ||
        (s_axi_araddr_in == IRQ_STATUS_OFFSET) ||
        (s_axi_araddr_in == IRQ_MASK_OFFSET) ||
        (s_axi_araddr_in == PIN_STATE_OFFSET);
    wire [31:0] nxt_rdata =
        (s_axi_araddr_in == CTRL_OFFSET) ? {24'h000000, ctrl_rd} :
        (s_axi_araddr_in == IRQ_STATUS_OFFSET) ? {30'h0, irq_status_ff} :
        (s_axi_araddr_in == IRQ_MASK_OFFSET) ? {30'h0, irq_mask_ff} :
        (s_axi_araddr_in == PIN_STATE_OFFSET) ? {30'h0, pins_sync} :
        32'h00000000;

    // Clock held in slave mode when released bit is zero or datapath asks
    wire nxt_scl_oe_n = !(mode_slave &&
        (!clock_release_ctl_ff || port_clk_hold_in)); // RL8

    // ==========================================================
    // Control register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            write_collision_flag_ff <= CTRL_RESET[WRITE_COLLISION_FLAG_BIT]; // RL11
            receive_overflow_flag_ff <= CTRL_RESET[ROV_BIT];
            serial_port_enable_ff <= CTRL_RESET[EN_BIT];
            clock_release_ctl_ff <= CTRL_RESET[CKR_BIT];
            port_mode_select_ff <= CTRL_RESET[3:0];
        end else begin
            write_collision_flag_ff <= nxt_write_collision_flag;
            receive_overflow_flag_ff <= nxt_rov;
            if (wr_ctrl) begin
                serial_port_enable_ff <= wr_data[EN_BIT]; // RL6
                clock_release_ctl_ff <= wr_data[CKR_BIT]; // RL8
                port_mode_select_ff <= wr_data[3:0]; // RL9
            end
        end
    end

    // ==========================================================
    // Interrupt status and mask
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_status_ff <= IRQ_RESET;
            irq_mask_ff <= IRQ_RESET;
            irq_out <= 1'b0;
        end else begin
            irq_status_ff <= nxt_irq_status;
            if (wr_mask) begin
                irq_mask_ff <= wr_data[1:0];
            end
            irq_out <= |(irq_status_ff & irq_mask_ff);
        end
    end

    // ==========================================================
    // Pin handover outputs
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            port_active_out <= 1'b0;
            port_mode_select_out <= 4'h0;
            master_mode_out <= 1'b0;
            slave_mode_out <= 1'b0;
            scl_oe_n_out <= 1'b1;
        end else begin
            port_active_out <= serial_port_enable_ff; // RL6
            port_mode_select_out <= port_mode_select_ff;
            master_mode_out <= mode_master;
            slave_mode_out <= mode_slave;
            scl_oe_n_out <= nxt_scl_oe_n;
        end
    end

    // ==========================================================
    // AXI write channel
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            awaddr_ff <= 4'h0;
            wdata_ff <= 32'h00000000;
            wstrb_ff <= 4'h0;
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out <= 1'b1;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_ff <= s_axi_awaddr_in;
            end
            if (w_take) begin
                wdata_ff <= s_axi_wdata_in;
                wstrb_ff <= s_axi_wstrb_in;
            end
            if (wr_fire) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_awready_out <= 1'b0;
                s_axi_wready_out <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end else begin
                if (aw_take) begin
                    aw_held_ff <= 1'b1;
                    s_axi_awready_out <= 1'b0;
                end
                if (w_take) begin
                    w_held_ff <= 1'b1;
                    s_axi_wready_out <= 1'b0;
                end
                if (s_axi_bvalid_out && s_axi_bready_in) begin
                    s_axi_bvalid_out <= 1'b0;
                    s_axi_awready_out <= 1'b1;
                    s_axi_wready_out <= 1'b1;
                end
            end
        end
    end

    // ==========================================================
    // AXI read channel
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h00000000;
            s_axi_rresp_out <= RESP_OKAY;
        end else if (rd_fire) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rdata_out <= nxt_rdata;
            s_axi_rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    // ==========================================================
    // Checks
    a_coll_sets_flag: assert property ( // RL1
        @(posedge clk_in) disable iff (!resetn_in)
        coll_evt |=> write_collision_flag_ff && irq_status_ff[0])
        else $error("collision did not set flag");
    a_ovf_sets_flag: assert property ( // RL3
        @(posedge clk_in) disable iff (!resetn_in)
        ovf_evt |=> receive_overflow_flag_ff)
        else $error("overflow did not set flag");
    a_ovf_not_master: assert property ( // RL10
        @(posedge clk_in) disable iff (!resetn_in)
        (mode_master && !receive_overflow_flag_ff) |=>
        !receive_overflow_flag_ff)
        else $error("overflow set in master mode");
    a_ovf_not_tx: assert property ( // RL4
        @(posedge clk_in) disable iff (!resetn_in)
        (tx_in_progress_in && !receive_overflow_flag_ff) |=>
        !receive_overflow_flag_ff)
        else $error("overflow set while transmitting");
    a_flag_no_hw_clr: assert property ( // RL5
        @(posedge clk_in) disable iff (!resetn_in)
        (write_collision_flag_ff && !wr_ctrl) |=> write_collision_flag_ff)
        else $error("collision flag cleared without write");
    a_clk_stretch: assert property ( // RL8
        @(posedge clk_in) disable iff (!resetn_in)
        (mode_slave && !clock_release_ctl_ff) |=> !scl_oe_n_out)
        else $error("clock not held in slave stretch");
    a_master_no_hold: assert property ( // RL8
        @(posedge clk_in) disable iff (!resetn_in)
        !mode_slave |=> scl_oe_n_out)
        else $error("clock held outside slave mode");
    a_enable_pins: assert property ( // RL6
        @(posedge clk_in) disable iff (!resetn_in)
        ##1 port_active_out == $past(serial_port_enable_ff))
        else $error("pin handover does not follow enable");
    a_reserved_idle: assert property ( // RL9
        @(posedge clk_in) disable iff (!resetn_in)
        (port_mode_select_ff == 4'h0) |=> !master_mode_out && !slave_mode_out)
        else $error("reserved mode acted");
    a_ctrl_reset: assert property ( // RL11
        @(posedge clk_in) $rose(resetn_in) |-> ctrl_rd == CTRL_RESET)
        else $error("control not zero after reset");
endmodule : i2cpc_ctrl
`default_nettype wire

/* i2cpc_pkg.sv */
/*
 * Package for the serial port control and error-flag block: register
 * offsets, field positions, reset values, mode codes.
 * Assumes an AXI4-Lite master with 32-bit data on the one system clock.
 */
// Overview of operation
// [RL1] Master mode: buffer write while bus not ready to start sets collision flag.
// [RL2] Slave mode: buffer write while previous word shifts out sets collision flag.
// [RL3] Byte completes while buffer still full sets receive overflow flag.
// [RL4] Overflow flag is ignored, never set, while transmitting.
// [RL5] Hardware only sets both flags; firmware clears each by writing zero.
// [RL6] Enable bit one hands data and clock pins to the port; zero keeps GPIO.
// [RL7] Firmware sets pin directions before using the port in either mode.
// [RL8] Slave mode: clock-release zero holds clock low, one releases; master ignores.
// [RL9] Mode field codes 0110,0111,1000,1011,1110,1111; all others reserved.
// [RL10] Master mode never sets the receive overflow flag.
// [RL11] Control register reads zero after power-on reset.
package i2cpc_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0] CTRL_OFFSET = 4'h0;
    localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h4;
    localparam logic [3:0] IRQ_MASK_OFFSET = 4'h8;
    localparam logic [3:0] PIN_STATE_OFFSET = 4'hC;

    // ==========================================================
    // Control register fields
    localparam int WRITE_COLLISION_FLAG_BIT = 7;
    localparam int ROV_BIT = 6;
    localparam int EN_BIT = 5;
    localparam int CKR_BIT = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // ==========================================================
    // Mode codes
    localparam logic [3:0] MODE_SLV7 = 4'h6;
    localparam logic [3:0] MODE_SLV10 = 4'h7;
    localparam logic [3:0] MODE_MST = 4'h8;
    localparam logic [3:0] MODE_FWMST = 4'hB;
    localparam logic [3:0] MODE_SLV7_SP = 4'hE;
    localparam logic [3:0] MODE_SLV10_SP = 4'hF;

    // ==========================================================
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : i2cpc_pkg

/* i2cpc_sync.sv */
/*
 * Two-flip-flop synchroniser for a group of level inputs.
 * Assumes inputs are asynchronous to clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
module i2cpc_sync #(
    parameter int WIDTH = 2
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_ff;

    // ==========================================================
    // Two stage capture
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_ff <= '0;
            sync_out <= '0;
        end else begin
            meta_ff <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : i2cpc_sync
`default_nettype wire

/* i2cpc_far_model.sv */
/*
 * Far-side model: shift datapath events and the two-wire bus partner.
 * Assumes the bench calls its tasks just after a rising clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module i2cpc_far_model (
    input wire logic clk_in,
    input wire logic scl_oe_n_in,
    output logic buf_write_out,
    output logic bus_start_ok_out,
    output logic tx_in_progress_out,
    output logic rx_byte_done_out,
    output logic buffer_full_out,
    output logic port_clk_hold_out,
    output logic sda_pin_out,
    output logic scl_pin_out
);
    logic sda_low;

    // Pulled-up lines left as inputs; the partner may pull data low
    assign sda_pin_out = !sda_low;
    assign scl_pin_out = scl_oe_n_in;

    // Quiet datapath at time zero
    initial begin
        buf_write_out = 1'h0;
        bus_start_ok_out = 1'h0;
        tx_in_progress_out = 1'h0;
        rx_byte_done_out = 1'h0;
        buffer_full_out = 1'h0;
        port_clk_hold_out = 1'h0;
        sda_low = 1'h0;
    end

    // Partner pulls data low; datapath asks for a clock hold
    task automatic pins(input logic lo, input logic hold);
        sda_low <= lo;
        port_clk_hold_out <= hold;
    endtask : pins

    // Bus and buffer levels seen by the control block
    task automatic lines(input logic ok, input logic tx, input logic full);
        bus_start_ok_out <= ok;
        tx_in_progress_out <= tx;
        buffer_full_out <= full;
    endtask : lines

    // One-cycle buffer write or byte-done pulse, then one quiet cycle
    task automatic pulse(input logic rx);
        if (rx) begin
            rx_byte_done_out <= 1'h1;
        end else begin
            buf_write_out <= 1'h1;
        end
        @(posedge clk_in);
        buf_write_out <= 1'h0;
        rx_byte_done_out <= 1'h0;
        @(posedge clk_in);
    endtask : pulse
endmodule : i2cpc_far_model
`default_nettype wire

/* i2c_port_control_flags_tb_top.sv */
/*
 * Self-checking bench for the serial port control and flag block.
 * Assumes the package, design files and far-side model compile first.
 */
`timescale 1ns/100ps
`default_nettype none
module i2c_port_control_flags_tb_top;
    import i2cpc_pkg::*;
    logic clk_in = 1'h0;
    logic resetn_in = 1'h0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0, mode;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid;
    logic active, mst, slv, oe_n, irq, bw, ok, tx, rx, full, hold, sda, scl;
    logic [33:0] exp_q[$];
    int errors = 0;
    int compares = 0;

    // ==========================================================
    // Clock, design and far side
    always #2.5 clk_in = ~clk_in;

    i2cpc_ctrl i_i2cpc_ctrl (.clk_in(clk_in), .resetn_in(resetn_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
        .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .buf_write_in(bw), .bus_start_ok_in(ok),
        .tx_in_progress_in(tx), .rx_byte_done_in(rx), .buffer_full_in(full),
        .port_clk_hold_in(hold), .sda_pin_in(sda), .scl_pin_in(scl),
        .port_active_out(active), .port_mode_select_out(mode),
        .master_mode_out(mst), .slave_mode_out(slv), .scl_oe_n_out(oe_n),
        .irq_out(irq));

    i2cpc_far_model u_far (.clk_in(clk_in), .scl_oe_n_in(oe_n),
        .buf_write_out(bw), .bus_start_ok_out(ok), .tx_in_progress_out(tx),
        .rx_byte_done_out(rx), .buffer_full_out(full),
        .port_clk_hold_out(hold), .sda_pin_out(sda), .scl_pin_out(scl));

    // ==========================================================
    // Comparison, verdict and bus tasks
    task automatic check(input logic [33:0] seen, input logic [33:0] want);
        compares++;
        if (seen !== want) begin
            errors++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen,
                want);
        end
    endtask : check

    task automatic close_out();
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out

    task automatic hang(input int n);
        if (n >= 200) begin
            errors++;
            $display("wrong value at %0t: bus answer missing", $time);
            close_out();
        end
    endtask : hang

    // Write one byte lane; upper data bits random, they must be ignored
    task automatic wr(input logic [3:0] a, input logic [7:0] d,
        input logic [3:0] s, input logic [1:0] er);
        logic [31:0] r;
        int n;
        r = $urandom();
        n = 0;
        awaddr <= a;
        wdata <= {r[31:8], d};
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk_in);
            n++;
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
        end while (!bvalid && n < 200);
        hang(n);
        bready <= 1'h0;
        check(bresp, er);
        // Let an edge pass so a following call never re-drives bready now
        @(posedge clk_in);
    endtask : wr

    // Read: the expectation is queued, the monitor compares it
    task automatic rd(input logic [3:0] a, input logic [1:0] er,
        input logic [31:0] d);
        int n;
        n = 0;
        exp_q.push_back({er, d});
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk_in);
            n++;
            if (arvalid && arready) arvalid <= 1'h0;
        end while (!rvalid && n < 200);
        hang(n);
        rready <= 1'h0;
        // Let an edge pass so a following call never re-drives rready now
        @(posedge clk_in);
    endtask : rd

    // Read monitor takes the oldest note at each read answer
    always @(posedge clk_in) begin
        if (rvalid && rready) begin
            check({rresp, rdata}, exp_q.pop_front());
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        logic [3:0] modes[7];
        logic [3:0] m;
        void'($urandom(32'h1527B6F6));
        modes = '{MODE_SLV7, MODE_SLV10, MODE_MST, MODE_FWMST, MODE_SLV7_SP,
            MODE_SLV10_SP, 4'h0};
        do modes[6] = 4'($urandom_range(15));
        while (modes[6] inside {4'h6, 4'h7, 4'h8, 4'hB, 4'hE, 4'hF});
        repeat (6) @(posedge clk_in);
        resetn_in <= 1'h1;
        rd(CTRL_OFFSET, RESP_OKAY, 32'h0);
        rd(IRQ_STATUS_OFFSET, RESP_OKAY, 32'h0);
        rd(IRQ_MASK_OFFSET, RESP_OKAY, 32'h0);
        check(active, 1'h0);
        // Every mode code, plus one random reserved code
        foreach (modes[i]) begin
            m = modes[i];
            wr(CTRL_OFFSET, {4'h3, m}, 4'hF, RESP_OKAY);
            rd(CTRL_OFFSET, RESP_OKAY, {24'h0, 4'h3, m});
            check(mode, m);
            check(mst, m inside {MODE_MST, MODE_FWMST});
            check(slv, m inside {4'h6, 4'h7, 4'hE, 4'hF});
            check(active, 1'h1);
        end
        // Master: collision, no overflow, interrupt path, clearing
        wr(CTRL_OFFSET, 8'h28, 4'hF, RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check(oe_n, 1'h1);
        u_far.lines(1'h0, 1'h0, 1'h1);
        u_far.pulse(1'h0);
        u_far.pulse(1'h1);
        rd(CTRL_OFFSET, RESP_OKAY, 32'hA8);
        rd(IRQ_STATUS_OFFSET, RESP_OKAY, 32'h1);
        check(irq, 1'h0);
        wr(IRQ_MASK_OFFSET, 8'h3, 4'hF, RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check(irq, 1'h1);
        wr(IRQ_STATUS_OFFSET, 8'h1, 4'hF, RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check(irq, 1'h0);
        wr(CTRL_OFFSET, 8'hA8, 4'hF, RESP_OKAY);
        rd(CTRL_OFFSET, RESP_OKAY, 32'hA8);
        wr(CTRL_OFFSET, 8'h28, 4'hF, RESP_OKAY);
        u_far.lines(1'h1, 1'h0, 1'h0);
        u_far.pulse(1'h0);
        rd(CTRL_OFFSET, RESP_OKAY, 32'h28);
        // Slave: clock stretch, collision, overflow
        wr(CTRL_OFFSET, 8'h26, 4'hF, RESP_OKAY);
        repeat (4) @(posedge clk_in);
        check(oe_n, 1'h0);
        rd(PIN_STATE_OFFSET, RESP_OKAY, 32'h2);
        wr(CTRL_OFFSET, 8'h36, 4'hF, RESP_OKAY);
        repeat (4) @(posedge clk_in);
        check(oe_n, 1'h1);
        rd(PIN_STATE_OFFSET, RESP_OKAY, 32'h3);
        // Datapath hold stretches the clock; partner pulls data low
        u_far.pins(1'h1, 1'h1);
        repeat (4) @(posedge clk_in);
        check(oe_n, 1'h0);
        rd(PIN_STATE_OFFSET, RESP_OKAY, 32'h0);
        u_far.pins(1'h0, 1'h0);
        repeat (4) @(posedge clk_in);
        check(oe_n, 1'h1);
        u_far.lines(1'h1, 1'h1, 1'h1);
        u_far.pulse(1'h0);
        u_far.pulse(1'h1);
        rd(CTRL_OFFSET, RESP_OKAY, 32'hB6);
        u_far.lines(1'h1, 1'h0, 1'h1);
        u_far.pulse(1'h1);
        rd(CTRL_OFFSET, RESP_OKAY, 32'hF6);
        rd(IRQ_STATUS_OFFSET, RESP_OKAY, 32'h3);
        check(irq, 1'h1);
        wr(CTRL_OFFSET, 8'h36, 4'hF, RESP_OKAY);
        rd(CTRL_OFFSET, RESP_OKAY, 32'h36);
        // Refused accesses leave the register alone
        wr(CTRL_OFFSET, 8'h00, 4'h0, RESP_OKAY);
        wr(4'h2, 8'hFF, 4'hF, RESP_SLVERR);
        rd(4'h2, RESP_SLVERR, 32'h0);
        rd(CTRL_OFFSET, RESP_OKAY, 32'h36);
        wr(CTRL_OFFSET, 8'h06, 4'hF, RESP_OKAY);
        repeat (3) @(posedge clk_in);
        check(active, 1'h0);
        check(slv, 1'h0);
        close_out();
    end
endmodule : i2c_port_control_flags_tb_top
`default_nettype wire
